// File: hw/ssc_pkg.sv
// Purpose: shared constants and types for the synchronous serial controller
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes:   register offsets are byte addresses on a 32-bit plain register port
package ssc_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] SSC_ADR_CTRL = 8'h00;
    localparam logic [7:0] SSC_ADR_BAUD = 8'h04;
    localparam logic [7:0] SSC_ADR_TXBUF = 8'h08;
    localparam logic [7:0] SSC_ADR_RXBUF = 8'h0C;
    localparam logic [7:0] SSC_ADR_STAT = 8'h10;
    localparam logic [7:0] SSC_ADR_CMD = 8'h14;

    // command register bit positions (write only, self clearing)
    localparam int unsigned SSC_CMD_START = 0;
    localparam int unsigned SSC_CMD_STOP = 1;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int unsigned SSC_MAX_BITS = 16;
    localparam logic [15:0] SSC_BAUD_RST = 16'h0008;
    localparam logic [3:0] SSC_WIDTH_RST = 4'h7;

    // control register, bit 0 upward from the last field
    typedef struct packed {
        logic ack_low;        // bit 13: drive the last bit of a frame low in two-wire mode
        logic pair_sel;       // bit 12: which of the two line pairs is used
        logic swap;           // bit 11: exchange clock and data lines of the pair
        logic i2c_mode;       // bit 10
        logic loopback;       // bit 9
        logic enable;         // bit 8
        logic master;         // bit 7
        logic polarity;       // bit 6
        logic phase;          // bit 5
        logic heading;        // bit 4: 1 msb first
        logic [3:0] width;    // bits 3:0: frame length minus one
    } ssc_ctrl_t;

    localparam ssc_ctrl_t SSC_CTRL_RST = '{width: SSC_WIDTH_RST, default: 1'b0};

    // status register, bit 0 upward from the last field
    typedef struct packed {
        logic stop_seen;      // bit 7, write one to clear
        logic start_seen;     // bit 6, write one to clear
        logic arb_lost;       // bit 5, write one to clear
        logic busy;           // bit 4
        logic rx_err;         // bit 3, write one to clear
        logic tx_err;         // bit 2, cleared by a transmit buffer write
        logic rx_full;        // bit 1, cleared by a receive buffer read
        logic tx_empty;       // bit 0
    } ssc_stat_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ssc_bus_req_t;

    // line0/line1 hold one bit per line pair; data_b is the second data pad
    typedef struct packed {
        logic [1:0] line0;
        logic [1:0] line1;
        logic data_b;
    } ssc_pads_t;

    typedef enum logic [1:0] {
        SSC_IDLE = 2'b00,
        SSC_START = 2'b01,
        SSC_XFER = 2'b11,
        SSC_STOP = 2'b10
    } ssc_state_t;

endpackage : ssc_pkg

// File: hw/ssc_baud_gen.sv
// Purpose: half-cycle down-counter for the master serial clock
// Assumes: reload of zero is never programmed; it behaves like one
// Notes:   the reload value is sampled when the counter reloads and on every clock while run is low
`timescale 1ns/1ps
module ssc_baud_gen
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic run,
    input wire logic stall,
    input wire logic [15:0] reload,
    output logic [15:0] count,
    output logic tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } ssc_baud_state_t;

    ssc_baud_state_t q;
    ssc_baud_state_t d;

    always_comb begin
        d = q;
        d.tick = 1'b0;
        if (!run) begin
            d.cnt = reload;
        end else if (!stall) begin
            if (q.cnt <= 16'h0001) begin
                d.cnt = reload;                      // see [RULE17] see [RULE27]
            end else begin
                d.cnt = q.cnt - 16'h0001;            // see [RULE14]
            end
            d.tick = d.cnt <= 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{cnt: SSC_BAUD_RST, tick: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign count = q.cnt;
    assign tick = q.tick;

endmodule : ssc_baud_gen

// File: hw/ssc_core.sv
// What this block does
// [RULE1] load 2..16 bit frame, shift out and in
// [RULE2] full frame copied into receive buffer
// [RULE3] master drives clock, slave follows external clock
// [RULE4] requests: transmit empty, receive full, error
// [RULE5] loopback routes data output to input
// [RULE6] pad control picks data in/out ports
// [RULE7] unselected output low, high in two-wire
// [RULE8] software disables the unselected pad driver
// [RULE9] software sets pad direction and driver type
// [RULE10] master clock idles at polarity level
// [RULE11] phase places pulse in second/first half
// [RULE12] incoming data latched mid bit period
// [RULE13] load at start, shift end, unload last
// [RULE14] bit rate is clock over twice reload
// [RULE15] software never programs reload zero
// [RULE16] software keeps reload at eight or more
// [RULE17] counter reloads each half, toggles at one
// [RULE18] baud read returns live counter value
// [RULE19] two-wire mode uses data line only
// [RULE20] arbitration, acknowledge, start/stop, clock stretching
// [RULE21] swap clock/data lines, choose line pair
// [RULE22] selectable msb-first or lsb-first shifting
// [RULE23] heading bit one means msb first
// [RULE24] width field is frame length minus one
// [RULE25] master bit one selects master mode
// [RULE26] enable bit gates all serial data activity
// [RULE27] new reload value applies at next reload
//
// Purpose: synchronous serial controller with pad selection and master clock
// Assumes: pad direction and drive type are set by software outside
// Notes:   all pad inputs pass a two-stage synchroniser before use
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
module ssc_core
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssc_bus_req_t bus_req,
    output logic [31:0] rd_data,
    input wire ssc_pads_t pads_in,
    output ssc_pads_t pads_out,
    output logic irq_tx_empty,
    output logic irq_rx_full,
    output logic irq_error
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        ssc_pads_t s1;
        ssc_pads_t s2;
        logic scl_prev;
        logic sda_prev;
        ssc_ctrl_t ctrl;
        logic [15:0] baud;
        logic [15:0] txbuf;
        logic [15:0] rxbuf;
        logic [15:0] sr;
        logic [4:0] bitcnt;
        logic tx_full;
        logic loaded;
        logic pend;
        logic rx_bit;
        logic half;
        logic sda_hold;
        logic start_req;
        logic stop_req;
        ssc_state_t state;
        ssc_stat_t stat;
        logic [31:0] rd_data;
        ssc_pads_t pads_out;
        logic irq_tx_empty;
        logic irq_rx_full;
        logic irq_error;
    } ssc_core_state_t;

    ssc_core_state_t q;
    ssc_core_state_t d;

    logic [15:0] baud_count;
    logic baud_tick;
    logic baud_run;
    logic baud_stall;

    // ------------------------------------------------------------------
    // baud generator
    // ------------------------------------------------------------------
    ssc_baud_gen u_baud (
        .clk(clk),
        .rst(rst),
        .run(baud_run),
        .stall(baud_stall),
        .reload(q.baud),
        .count(baud_count),
        .tick(baud_tick)
    );

    // helper values taken from registered state only
    logic scl_in;
    logic sda_in;
    logic din;
    logic scl_drv;
    logic tx_bit_q;

    always_comb begin
        scl_in = q.ctrl.swap ? q.s2.line1[q.ctrl.pair_sel] : q.s2.line0[q.ctrl.pair_sel];  // see [RULE21]
        sda_in = q.ctrl.swap ? q.s2.line0[q.ctrl.pair_sel] : q.s2.line1[q.ctrl.pair_sel];
        scl_drv = q.ctrl.swap ? q.pads_out.line1[q.ctrl.pair_sel]
                              : q.pads_out.line0[q.ctrl.pair_sel];
        tx_bit_q = q.ctrl.heading ? q.sr[q.ctrl.width] : q.sr[0];
        if (q.ctrl.i2c_mode && q.ctrl.ack_low && q.bitcnt == {1'b0, q.ctrl.width}) begin
            tx_bit_q = 1'b0;                                         // see [RULE20]
        end
        if (q.ctrl.loopback) begin
            din = tx_bit_q;                                          // see [RULE5]
        end else if (q.ctrl.i2c_mode || !q.ctrl.master) begin
            din = sda_in;                                            // see [RULE6] see [RULE19]
        end else begin
            din = q.s2.data_b;
        end
    end

    assign baud_run = q.ctrl.enable && q.ctrl.master && (q.state != SSC_IDLE);
    // a slave holding the clock low stretches the current half period
    assign baud_stall = q.ctrl.i2c_mode && q.state == SSC_XFER && scl_drv && !scl_in;  // see [RULE20]

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic lat_ev;
    logic sh_ev;
    logic rel_now;
    logic rel_prev;
    logic frame_done;
    logic tx_bit;
    logic scl_val;
    logic sda_val;
    logic b_val;
    logic idle_lvl;

    always_comb begin
        d = q;
        lat_ev = 1'b0;
        sh_ev = 1'b0;
        frame_done = 1'b0;
        tx_bit = 1'b0;
        scl_val = 1'b0;
        sda_val = 1'b0;
        b_val = 1'b0;
        idle_lvl = 1'b0;
        rel_now = scl_in ^ q.ctrl.polarity;
        rel_prev = q.scl_prev ^ q.ctrl.polarity;

        d.s1 = pads_in;
        d.s2 = q.s1;
        d.scl_prev = scl_in;
        d.sda_prev = sda_in;
        d.rd_data = 32'h0000_0000;

        // --------------------------------------------------------------
        // register port
        // --------------------------------------------------------------
        if (bus_req.wr) begin
            case (bus_req.addr)
                SSC_ADR_CTRL: d.ctrl = bus_req.wdata[$bits(ssc_ctrl_t)-1:0];
                SSC_ADR_BAUD: d.baud = bus_req.wdata[15:0];          // see [RULE27]
                SSC_ADR_TXBUF: begin
                    d.txbuf = bus_req.wdata[15:0];
                    d.tx_full = 1'b1;
                    d.stat.tx_err = 1'b0;
                end
                SSC_ADR_STAT: begin
                    if (bus_req.wdata[3]) d.stat.rx_err = 1'b0;
                    if (bus_req.wdata[5]) d.stat.arb_lost = 1'b0;
                    if (bus_req.wdata[6]) d.stat.start_seen = 1'b0;
                    if (bus_req.wdata[7]) d.stat.stop_seen = 1'b0;
                end
                SSC_ADR_CMD: begin
                    if (bus_req.wdata[SSC_CMD_START]) d.start_req = 1'b1;
                    if (bus_req.wdata[SSC_CMD_STOP]) d.stop_req = 1'b1;
                end
                default: ;
            endcase
        end
        if (bus_req.rd) begin
            case (bus_req.addr)
                SSC_ADR_CTRL: d.rd_data = {18'h0_0000, q.ctrl};
                SSC_ADR_BAUD: d.rd_data = {16'h0000, baud_count};    // see [RULE18]
                SSC_ADR_TXBUF: d.rd_data = {16'h0000, q.txbuf};
                SSC_ADR_RXBUF: begin
                    d.rd_data = {16'h0000, q.rxbuf};
                    d.stat.rx_full = 1'b0;
                end
                SSC_ADR_STAT: d.rd_data = {24'h00_0000, q.stat};
                default: d.rd_data = 32'h0000_0000;
            endcase
        end

        // --------------------------------------------------------------
        // bus condition detection, two-wire mode
        // --------------------------------------------------------------
        if (q.ctrl.i2c_mode && q.ctrl.enable && scl_in && q.scl_prev) begin
            if (q.sda_prev && !sda_in) d.stat.start_seen = 1'b1;    // see [RULE20]
            if (!q.sda_prev && sda_in) d.stat.stop_seen = 1'b1;
        end

        // --------------------------------------------------------------
        // bit events: master from the baud tick, slave from clock edges
        // --------------------------------------------------------------
        if (q.ctrl.enable) begin                                     // see [RULE26]
            if (q.ctrl.master) begin                                 // see [RULE25] see [RULE3]
                case (q.state)
                    SSC_IDLE: begin
                        if (q.stop_req) begin
                            d.state = SSC_STOP;
                            d.half = 1'b0;
                        end else if (q.start_req) begin
                            d.state = SSC_START;
                        end else if (q.loaded) begin
                            d.state = SSC_XFER;
                            d.half = 1'b0;
                            d.sda_hold = 1'b0;
                        end
                    end
                    SSC_START: begin
                        if (baud_tick) begin
                            d.start_req = 1'b0;
                            d.sda_hold = 1'b1;
                            d.state = SSC_IDLE;
                        end
                    end
                    SSC_XFER: begin
                        if (baud_tick) begin
                            d.half = !q.half;
                            lat_ev = !q.half;                        // see [RULE12]
                            sh_ev = q.half;                          // see [RULE13]
                        end
                    end
                    SSC_STOP: begin
                        if (baud_tick) begin
                            d.half = 1'b1;
                            if (q.half) begin
                                d.stop_req = 1'b0;
                                d.sda_hold = 1'b0;
                                d.state = SSC_IDLE;
                            end
                        end
                    end
                    default: d.state = SSC_IDLE;
                endcase
            end else begin
                d.state = SSC_IDLE;
                // latch on the mid-period edge, shift on the end-of-period edge
                if (q.ctrl.phase) begin
                    lat_ev = rel_prev && !rel_now;
                    sh_ev = !rel_prev && rel_now;
                end else begin
                    lat_ev = !rel_prev && rel_now;
                    sh_ev = rel_prev && !rel_now;
                end
            end
        end else begin
            d.state = SSC_IDLE;
            d.bitcnt = 5'd0;
            d.pend = 1'b0;
            d.half = 1'b0;
        end

        // --------------------------------------------------------------
        // latch, shift, unload
        // --------------------------------------------------------------
        if (lat_ev) begin
            d.rx_bit = din;
            d.pend = 1'b1;
            if (!q.ctrl.master && q.bitcnt == 5'd0 && !q.loaded) begin
                d.stat.tx_err = 1'b1;                                // see [RULE4]
            end
            // losing a driven one on the wire hands the bus to the other master
            if (q.ctrl.master && q.ctrl.i2c_mode && tx_bit_q && !din) begin
                d.stat.arb_lost = 1'b1;                              // see [RULE20]
                d.ctrl.master = 1'b0;
                d.state = SSC_IDLE;
                d.bitcnt = 5'd0;
                d.pend = 1'b0;
                d.loaded = 1'b0;
            end
        end
        if (sh_ev && q.pend) begin
            d.pend = 1'b0;
            if (q.ctrl.heading) begin                                // see [RULE22] see [RULE23]
                d.sr = {q.sr[14:0], q.rx_bit};
            end else begin
                d.sr = q.sr >> 1;
                d.sr[q.ctrl.width] = q.rx_bit;
            end
            d.bitcnt = q.bitcnt + 5'd1;                              // see [RULE1]
            if (q.bitcnt == {1'b0, q.ctrl.width}) begin              // see [RULE24]
                frame_done = 1'b1;
                d.bitcnt = 5'd0;
                d.loaded = 1'b0;
                d.rxbuf = d.sr;                                      // see [RULE2] see [RULE13]
                if (q.stat.rx_full) d.stat.rx_err = 1'b1;
                d.stat.rx_full = 1'b1;
            end
        end

        // shift register takes the next frame only between frames
        if (q.ctrl.enable && d.bitcnt == 5'd0 && !d.loaded && d.tx_full) begin
            d.sr = d.txbuf;                                          // see [RULE1] see [RULE13]
            d.tx_full = 1'b0;
            d.loaded = 1'b1;
        end
        if (q.state == SSC_XFER && frame_done && !d.loaded) begin
            d.state = SSC_IDLE;
        end

        d.stat.tx_empty = !d.tx_full;
        d.stat.busy = (d.state != SSC_IDLE) || (d.bitcnt != 5'd0);

        // --------------------------------------------------------------
        // pad outputs, registered
        // --------------------------------------------------------------
        tx_bit = d.ctrl.heading ? d.sr[d.ctrl.width] : d.sr[0];
        if (d.ctrl.i2c_mode && d.ctrl.ack_low && d.bitcnt == {1'b0, d.ctrl.width}) begin
            tx_bit = 1'b0;
        end
        if (d.state == SSC_XFER) begin
            scl_val = d.ctrl.polarity ^ (d.half ^ d.ctrl.phase);     // see [RULE10] see [RULE11]
        end else begin
            scl_val = d.ctrl.polarity;                               // see [RULE10]
        end
        if (!d.ctrl.master) begin
            scl_val = 1'b1;
        end
        idle_lvl = d.ctrl.i2c_mode;                                  // see [RULE7]
        if (!d.ctrl.enable) begin
            sda_val = idle_lvl;
            b_val = idle_lvl;
        end else if (d.ctrl.i2c_mode) begin
            sda_val = tx_bit;                                        // see [RULE19]
            if (d.state == SSC_START || d.state == SSC_STOP) begin
                sda_val = (d.state == SSC_STOP) && d.half;
            end else if (d.sda_hold) begin
                sda_val = 1'b0;
            end
            b_val = idle_lvl;                                        // see [RULE7]
        end else if (d.ctrl.master) begin
            sda_val = tx_bit;                                        // see [RULE6]
            b_val = idle_lvl;
        end else begin
            sda_val = idle_lvl;
            b_val = tx_bit;
        end
        d.pads_out.data_b = b_val;
        for (int p = 0; p < 2; p++) begin
            if (p == int'(d.ctrl.pair_sel)) begin                    // see [RULE21]
                d.pads_out.line0[p] = d.ctrl.swap ? sda_val : scl_val;
                d.pads_out.line1[p] = d.ctrl.swap ? scl_val : sda_val;
            end else begin
                d.pads_out.line0[p] = 1'b1;
                d.pads_out.line1[p] = 1'b1;
            end
        end

        d.irq_tx_empty = d.stat.tx_empty;                            // see [RULE4]
        d.irq_rx_full = d.stat.rx_full;
        d.irq_error = d.stat.tx_err || d.stat.rx_err || d.stat.arb_lost;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.ctrl <= SSC_CTRL_RST;
            q.baud <= SSC_BAUD_RST;
            q.state <= SSC_IDLE;
            q.stat.tx_empty <= 1'b1;
            q.pads_out <= '{line0: 2'b11, line1: 2'b11, data_b: 1'b0};
            q.irq_tx_empty <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign rd_data = q.rd_data;
    assign pads_out = q.pads_out;
    assign irq_tx_empty = q.irq_tx_empty;
    assign irq_rx_full = q.irq_rx_full;
    assign irq_error = q.irq_error;

endmodule : ssc_core

// File: tb/ssc_core_checker.sv
// Purpose: port checker for ssc_core
// Assumes: baud reload stays 8 or more, no arbitration loss
// Notes: mirrors ctrl and baud writes to know the mode
`timescale 1ns/1ps
module ssc_core_checker
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssc_bus_req_t bus_req,
    input wire logic [31:0] rd_data,
    input wire ssc_pads_t pads_out,
    input wire logic irq_rx_full
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ssc_ctrl_t c_q;
    logic [15:0] b_q;
    logic [15:0] bo_q;
    logic [2:0] qt_q;
    logic idle_q;
    logic wc;
    logic mst;
    assign wc = bus_req.wr && bus_req.addr == SSC_ADR_CTRL;
    // settled master mode on pair 0; a fresh ctrl write may move the clock on purpose
    assign mst = qt_q == 3'h7 && c_q.master && c_q.enable && !c_q.i2c_mode && !c_q.swap
        && !c_q.pair_sel;
    always_ff @(posedge clk) begin
        if (rst) begin
            c_q <= SSC_CTRL_RST;
            b_q <= SSC_BAUD_RST;
            bo_q <= SSC_BAUD_RST;
            qt_q <= 3'h0;
            idle_q <= 1'b0;
        end else begin
            if (wc) c_q <= ssc_ctrl_t'(bus_req.wdata[13:0]);
            if (bus_req.wr && bus_req.addr == SSC_ADR_BAUD) bo_q <= b_q;
            if (bus_req.wr && bus_req.addr == SSC_ADR_BAUD) b_q <= bus_req.wdata[15:0];
            qt_q <= wc ? 3'h0 : (qt_q == 3'h7 ? qt_q : qt_q + 3'h1);
            idle_q <= wc | (idle_q & ~(bus_req.wr && bus_req.addr == SSC_ADR_TXBUF));
        end
    end
    AST_BAUD_LIVE: assert property (bus_req.rd && bus_req.addr == SSC_ADR_BAUD
        |=> rd_data[15:0] <= (b_q > bo_q ? b_q : bo_q) && rd_data[31:16] == 16'h0000)
        else $error("baud read above reload");
    AST_HALF_MIN: assert property (mst && $changed(pads_out.line0[0])
        |=> $stable(pads_out.line0[0]) [*7])
        else $error("clock half period too short");
    AST_IDLE_LVL: assert property (idle_q && mst
        |-> pads_out.line0[0] == c_q.polarity)
        else $error("idle clock level wrong");
    AST_DIS_LOW: assert property (qt_q == 3'h7 && !c_q.enable && !c_q.i2c_mode
        |-> !pads_out.data_b)
        else $error("disabled data pad driven");
    AST_DESEL_LOW: assert property (mst |-> !pads_out.data_b)
        else $error("deselected data pad not low");
    AST_DESEL_I2C: assert property (qt_q == 3'h7 && c_q.master && c_q.i2c_mode
        |-> pads_out.data_b)
        else $error("deselected data pad not high");
    AST_PAIR_OFF: assert property (qt_q == 3'h7 && !c_q.pair_sel
        |-> pads_out.line0[1] && pads_out.line1[1])
        else $error("unselected pair driven");
    AST_RX_CLEAR: assert property (bus_req.rd && bus_req.addr == SSC_ADR_RXBUF
        && irq_rx_full |-> ##[1:3] !irq_rx_full)
        else $error("receive full not cleared");
    cover property (bus_req.wr && bus_req.addr == SSC_ADR_TXBUF && c_q.master);
    cover property ($rose(irq_rx_full));
    cover property (mst && $changed(pads_out.line0[0]));
endmodule : ssc_core_checker
bind ssc_core ssc_core_checker ssc_core_checker_inst (.clk(clk), .rst(rst), .bus_req(bus_req),
    .rd_data(rd_data), .pads_out(pads_out), .irq_rx_full(irq_rx_full));

// File: tb/ssc_far_end.sv
// Purpose: far-end bus device for the serial controller bench
// Assumes: pads wired straight to the device
// Notes: answers every data bit inverted on both return pads
`timescale 1ns/1ps
module ssc_far_end
    import ssc_pkg::*;
(
    input wire ssc_pads_t pads_out,
    output ssc_pads_t pads_in
);
    always_comb begin
        pads_in = pads_out;
        // its own drive wins on the return pads, the device drive is off there
        pads_in.line1[0] = ~pads_out.line1[0];
        pads_in.data_b = ~pads_out.line1[0];
    end
endmodule : ssc_far_end

// File: tb/tb.sv
// Purpose: self-checking bench for ssc_core
// Assumes: baud reload 9 for all frames
// Notes: each table row runs one master frame
`timescale 1ns/1ps
module tb;
    import ssc_pkg::*;
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] tx;
        logic [15:0] rx;
    } ssc_row_t;
    logic clk;
    logic rst;
    ssc_bus_req_t req;
    logic [31:0] rd_data;
    ssc_pads_t pads_in;
    ssc_pads_t pads_out;
    logic irq_tx_empty;
    logic irq_rx_full;
    logic irq_error;
    int bad_count = 0;
    int num_checks = 0;
    ssc_row_t rows [6] = '{'{16'h0397, 16'h00A5, 16'h00A5}, '{16'h0181, 16'h0002, 16'h0001},
        '{16'h039F, 16'h1234, 16'h1234}, '{16'h01CF, 16'h8001, 16'h7FFE},
        '{16'h03A7, 16'h003C, 16'h003C}, '{16'h0193, 16'h000A, 16'h0005}};
    logic [7:0] ra [4] = '{SSC_ADR_CTRL, SSC_ADR_BAUD, SSC_ADR_STAT, 8'h20};
    logic [31:0] rv [4] = '{32'h0000_0007, 32'h0000_0008, 32'h0000_0001, 32'h0000_0000};
    ssc_core ssc_core_inst (.clk(clk), .rst(rst), .bus_req(req), .rd_data(rd_data),
        .pads_in(pads_in), .pads_out(pads_out), .irq_tx_empty(irq_tx_empty),
        .irq_rx_full(irq_rx_full), .irq_error(irq_error));
    ssc_far_end ssc_far_end_inst (.pads_out(pads_out), .pads_in(pads_in));
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rd_data;
    endtask : rd
    // edges until the pair 0 clock line moves; bounded so a dead clock shows as a bad count
    task automatic clk_move(output int n);
        logic l;
        #1 l = pads_out.line0[0];
        n = 0;
        while (pads_out.line0[0] === l && n < 600) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : clk_move
    task automatic wait_set(input int sel);
        int n;
        n = 0;
        while ((sel == 0 ? irq_rx_full : irq_error) !== 1'b1 && n < 2000) begin
            @(posedge clk);
            #1 n++;
        end
        chk("wait bound", 32'h0000_0000, {31'h0, n == 2000});
    endtask : wait_set
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        #2000000;
        bad_count++;
        results();
    end
    initial begin
        int n;
        logic [31:0] d;
        logic [31:0] m;
        rst = 1'b1;
        req = '0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wr(SSC_ADR_BAUD, 32'h0000_0009);
        foreach (rows[i]) begin
            wr(SSC_ADR_CTRL, {16'h0000, rows[i].ctrl});
            repeat (8) @(posedge clk);
            #1 chk("idle clock", 32'(rows[i].ctrl[6]), 32'(pads_out.line0[0]));
            wr(SSC_ADR_TXBUF, {16'h0000, rows[i].tx});
            clk_move(n);
            d = {31'h0, rows[i].ctrl[4] ? rows[i].tx[rows[i].ctrl[3:0]] : rows[i].tx[0]};
            if (!rows[i].ctrl[5] && !rows[i].ctrl[9])
                chk("first bit", d, {31'h0, pads_out.line1[0]});
            clk_move(n);
            chk("half period", 32'h0000_0009, n);
            rd(SSC_ADR_BAUD, d);
            wait_set(0);
            rd(SSC_ADR_RXBUF, d);
            m = (32'h0000_0002 << rows[i].ctrl[3:0]) - 32'h0000_0001;
            chk("rx data", {16'h0000, rows[i].rx}, d & m);
        end
        wr(SSC_ADR_CTRL, 32'h0000_0381);
        wr(SSC_ADR_TXBUF, 32'h0000_0001);
        wait_set(0);
        wr(SSC_ADR_TXBUF, 32'h0000_0002);
        wait_set(1);
        rd(SSC_ADR_STAT, d);
        chk("overrun flag", 32'h0000_0008, d & 32'h0000_0008);
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1 chk("tx empty", 32'h0000_0001, {31'h0, irq_tx_empty});
        chk("error", 32'h0000_0000, {31'h0, irq_error});
        foreach (ra[i]) begin
            rd(ra[i], d);
            chk("reset read", rv[i], d);
        end
        wr(SSC_ADR_CTRL, 32'h0000_0580);
        repeat (10) @(posedge clk);
        results();
    end
endmodule : tb
